// File: core/acm_pkg.sv
// Shared constants and types of the converter mode and option control.
// Assumes a single 250 MHz core clock; the core and the bench import this package, the host model does not.
`default_nettype none

package acm_pkg;

    // Core clock period and the conversion period it is counted in.
    localparam int CLK_PERIOD_NS = 4;
    localparam int CONV_PERIOD_NS = 1000;
    localparam int CONV_CLKS = CONV_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [9:0] CONV_LAST = 10'(CONV_CLKS - 1);
    // Filter latency of continuous conversion, in conversion cycles.
    localparam logic [2:0] SETTLE_CYCLES = 3'h5;

    // Command byte layout: mode in the top two bits.
    localparam int CMD_MODE_HI = 7;
    localparam int CMD_MODE_LO = 6;
    localparam int CMD_ADDR_HI = 5;
    localparam int CMD_ADDR_LO = 1;
    localparam int CMD_RD_BIT = 0;
    localparam logic [1:0] CMD_MODE_PD = 2'h1;
    localparam logic [1:0] CMD_MODE_CONV = 2'h2;
    localparam logic [1:0] CMD_MODE_REG = 2'h3;

    // Register addresses within a register-access command.
    localparam logic [4:0] ADDR_MODE = 5'h01;
    localparam logic [4:0] ADDR_OPT = 5'h02;
    localparam logic [4:0] ADDR_DATA = 5'h03;
    localparam logic [4:0] ADDR_STAT = 5'h04;

    // Values after reset.
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] OPT_RST = 8'h20;

    // Serial frame bit positions.
    localparam logic [4:0] BIT_CMD_LAST = 5'h07;
    localparam logic [4:0] BIT_WDATA_LAST = 5'h0F;

    // Power-down selections.
    localparam logic [1:0] PD_NOP = 2'h0;
    localparam logic [1:0] PD_SLEEP = 2'h1;
    localparam logic [1:0] PD_STANDBY = 2'h2;
    localparam logic [1:0] PD_RESET = 2'h3;

    localparam logic [1:0] SEQ_MODE1 = 2'h1;
    localparam logic [23:0] OFFSET_FLIP = 24'h800000;

    // Conversion mode register, most significant field first.
    typedef struct packed {
        logic [1:0] power_down_select;
        logic [1:0] reserved;
        logic unipolar;
        logic offset_binary;
        logic single_cycle_select;
        logic repeat_single_cycle;
    } acm_mode_t;

    // Optional-function control register, most significant field first.
    typedef struct packed {
        logic ext_clock_select;
        logic fault_current_enable;
        logic regulator_enable;
        logic amp_low_power;
        logic amp_enable;
        logic [2:0] amp_gain_code;
    } acm_opt_t;

    typedef enum {
        ST_SLEEP,
        ST_STANDBY,
        ST_CONV
    } acm_state_t;

endpackage : acm_pkg

`default_nettype wire

// File: core/acm_top.sv
// Serial register slave, conversion sequencer and option control outputs.
// Assumes the serial pins come from another domain and the modulator sample
// arrives on the core clock, valid at the end of each conversion period.
`default_nettype none

// Functional notes
// - Polarity bit 1 selects unipolar range, 0 selects bipolar range.
// - Bipolar: format 0 two's complement, 1 offset binary; unipolar straight.
// - Single-cycle 1: one conversion without latency, then sleep.
// - Single-cycle 0 under sequencer mode 1: continuous, first result after five conversion cycles.
// - Ready output goes low only when a settled result is readable.
// - In single-cycle mode 1 under sequencer mode 1, repeat bit 1 repeats, 0 converts once.
// - Option register resets to 0x20 with the documented bit order.
// - External clock bit bypasses oscillator; shared pin 0 becomes input.
// - Fault current bit switches on input current source and sink.
// - Regulator enable bit turns the core regulator on at 1.
// - Low-power bit reduces amplifier power, ignored while amplifier off.
// - Amplifier enable bit enables the amplifier at 1, disables at 0.
// - Gain code 000 is unity gain and the reset value.
// - Power-down field: nop, sleep, standby, reset, run by command mode 01.

module acm_top
    import acm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cs_n_i,
    input wire logic sclk_i,
    input wire logic sdi_i,
    output logic sdo_o,
    input wire logic [1:0] seq_mode_i,
    input wire logic [23:0] sample_i,
    output logic result_ready_n_o,
    output logic converting_o,
    output logic standby_o,
    output logic ext_clock_select_o,
    output logic shared_pin0_oe_o,
    output logic fault_current_enable_o,
    output logic regulator_enable_o,
    output logic amp_enable_o,
    output logic amp_low_power_o,
    output logic [7:0] amp_gain_o
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers.

    logic [1:0] rst_sync;
    logic rst_n;
    assign rst_n = rst_sync[1];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    // Three stages per pin; the filtered level moves only when the second
    // and third stages agree, so a single metastable sample never counts.
    logic [2:0] cs_s, sclk_s, sdi_s;
    logic cs_lvl, sclk_lvl, sdi_lvl;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cs_s <= 3'h7;
            sclk_s <= 3'h0;
            sdi_s <= 3'h0;
            cs_lvl <= 1'b1;
            sclk_lvl <= 1'b0;
            sdi_lvl <= 1'b0;
        end else begin
            cs_s <= {cs_s[1:0], cs_n_i};
            sclk_s <= {sclk_s[1:0], sclk_i};
            sdi_s <= {sdi_s[1:0], sdi_i};
            if (cs_s[1] == cs_s[2]) cs_lvl <= cs_s[2];
            if (sclk_s[1] == sclk_s[2]) sclk_lvl <= sclk_s[2];
            if (sdi_s[1] == sdi_s[2]) sdi_lvl <= sdi_s[2];
        end
    end

    wire sclk_new = (sclk_s[1] == sclk_s[2]) ? sclk_s[2] : sclk_lvl;
    wire sclk_rise = !cs_lvl && sclk_new && !sclk_lvl;
    wire sclk_fall = !cs_lvl && !sclk_new && sclk_lvl;

    ////////////////////////////////////////////////////////////////////////
    // Serial frame decode.

    logic [4:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] cmd;
    logic [23:0] shift_out;

    wire [7:0] byte_now = {shift_in[6:0], sdi_lvl};
    wire cmd_done = sclk_rise && bit_cnt == BIT_CMD_LAST;
    wire [1:0] cmd_mode = byte_now[CMD_MODE_HI:CMD_MODE_LO];
    wire [4:0] cmd_addr = byte_now[CMD_ADDR_HI:CMD_ADDR_LO];
    wire cmd_rd = byte_now[CMD_RD_BIT];
    wire pd_cmd = cmd_done && cmd_mode == CMD_MODE_PD;
    wire conv_cmd = cmd_done && cmd_mode == CMD_MODE_CONV;
    wire rd_cmd = cmd_done && cmd_mode == CMD_MODE_REG && cmd_rd;
    wire wr_done = sclk_rise && bit_cnt == BIT_WDATA_LAST
        && cmd[CMD_MODE_HI:CMD_MODE_LO] == CMD_MODE_REG && !cmd[CMD_RD_BIT];
    wire [4:0] wr_addr = cmd[CMD_ADDR_HI:CMD_ADDR_LO];
    wire data_read = rd_cmd && cmd_addr == ADDR_DATA;

    acm_mode_t mode_reg;
    acm_opt_t opt_reg;
    acm_state_t state;
    logic [23:0] data_reg;
    logic [2:0] settle;
    logic [23:0] read_word;

    always_comb begin
        case (cmd_addr)
            ADDR_MODE: read_word = {mode_reg, 16'h0000};
            ADDR_OPT: read_word = {opt_reg, 16'h0000};
            ADDR_DATA: read_word = data_reg;
            ADDR_STAT: read_word = {result_ready_n_o, converting_o,
                standby_o, 2'h0, settle, 16'h0000};
            default: read_word = 24'h000000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 5'h00;
            shift_in <= 8'h00;
            cmd <= 8'h00;
            shift_out <= 24'h000000;
            sdo_o <= 1'b0;
        end else if (cs_lvl) begin
            bit_cnt <= 5'h00;
            shift_out <= 24'h000000;
        end else if (sclk_rise) begin
            shift_in <= byte_now;
            bit_cnt <= (bit_cnt == 5'h1F) ? bit_cnt : bit_cnt + 5'h01;
            if (cmd_done) cmd <= byte_now;
            if (rd_cmd) shift_out <= read_word;
        end else if (sclk_fall) begin
            sdo_o <= shift_out[23];
            shift_out <= {shift_out[22:0], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file and power-down commands.

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_RST;
            opt_reg <= OPT_RST;
        end else if (pd_cmd && mode_reg.power_down_select == PD_RESET) begin
            mode_reg <= MODE_RST;
            opt_reg <= OPT_RST;
        end else if (wr_done && wr_addr == ADDR_MODE) begin
            mode_reg <= {shift_in[6:5], 2'h0, shift_in[2:0], sdi_lvl};
            mode_reg.reserved <= 2'h0;
        end else if (wr_done && wr_addr == ADDR_OPT) begin
            opt_reg <= byte_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer.

    // Range and format are latched at each conversion start (gain is not), so a
    // write during a conversion never splits one result across range or format.
    acm_mode_t cfg_l;
    logic [9:0] conv_cnt;
    logic settled;

    // Outside sequencer mode 1 the converter runs single-cycle regardless.
    wire single_eff = mode_reg.single_cycle_select
        || seq_mode_i != SEQ_MODE1;
    wire cfg_single = cfg_l.single_cycle_select || seq_mode_i != SEQ_MODE1;
    wire repeat_eff = cfg_l.repeat_single_cycle
        && seq_mode_i == SEQ_MODE1;
    wire conv_end = state == ST_CONV && conv_cnt == CONV_LAST;
    wire result_now = conv_end && (cfg_single
        || settle == SETTLE_CYCLES - 3'h1 || settled);
    wire stop_now = conv_end && cfg_single && !repeat_eff;
    wire pd_stop = pd_cmd && mode_reg.power_down_select != PD_NOP;

    function automatic logic [23:0] code_of(input acm_mode_t c,
                                            input logic [23:0] raw);
        if (c.unipolar) code_of = raw;
        else if (c.offset_binary) code_of = raw ^ OFFSET_FLIP;
        else code_of = raw;
    endfunction : code_of

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_SLEEP;
            cfg_l <= MODE_RST;
            conv_cnt <= 10'h000;
            settle <= 3'h0;
            settled <= 1'b0;
            data_reg <= 24'h000000;
        end else if (pd_stop) begin
            state <= mode_reg.power_down_select == PD_STANDBY
                ? ST_STANDBY : ST_SLEEP;
            conv_cnt <= 10'h000;
        end else if (conv_cmd && state != ST_CONV) begin
            state <= ST_CONV;
            cfg_l <= mode_reg;
            cfg_l.single_cycle_select <= single_eff;
            conv_cnt <= 10'h000;
            settle <= 3'h0;
            settled <= 1'b0;
        end else if (state == ST_CONV) begin
            conv_cnt <= conv_end ? 10'h000 : conv_cnt + 10'h001;
            if (conv_end) begin
                cfg_l <= mode_reg;
                if (result_now) data_reg <= code_of(cfg_l, sample_i);
                if (!settled) settle <= settle + 3'h1;
                if (settle == SETTLE_CYCLES - 3'h1) settled <= 1'b1;
                if (stop_now) state <= ST_SLEEP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs to the analog side and ready flag.

    function automatic logic [7:0] gain_of(input logic [2:0] code);
        gain_of = 8'h01 << code;
    endfunction : gain_of

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            result_ready_n_o <= 1'b1;
        end else if (result_now) begin
            result_ready_n_o <= 1'b0;
        end else if (data_read || (conv_cmd && state != ST_CONV)) begin
            result_ready_n_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            converting_o <= 1'b0;
            standby_o <= 1'b0;
            ext_clock_select_o <= 1'b0;
            shared_pin0_oe_o <= 1'b0;
            fault_current_enable_o <= 1'b0;
            regulator_enable_o <= 1'b1;
            amp_enable_o <= 1'b0;
            amp_low_power_o <= 1'b0;
            amp_gain_o <= 8'h01;
        end else begin
            converting_o <= state == ST_CONV;
            standby_o <= state == ST_STANDBY;
            ext_clock_select_o <= opt_reg.ext_clock_select;
            shared_pin0_oe_o <= 1'b0;
            fault_current_enable_o <= opt_reg.fault_current_enable;
            regulator_enable_o <= opt_reg.regulator_enable;
            amp_enable_o <= opt_reg.amp_enable;
            amp_low_power_o <= opt_reg.amp_low_power
                && opt_reg.amp_enable;
            amp_gain_o <= gain_of(opt_reg.amp_gain_code);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    property p_opt_reset;
        @(posedge clk_i) $rose(rst_n) |-> opt_reg == OPT_RST;
    endproperty
    a_opt_reset: assert property (p_opt_reset)
        else $error("Option register not at reset value.");

    property p_ready_only_result;
        @(posedge clk_i) disable iff (!rst_n)
        $fell(result_ready_n_o) |-> $past(result_now);
    endproperty
    a_ready_only_result: assert property (p_ready_only_result)
        else $error("Ready asserted without a result.");

    sequence s_single_start;
        conv_cmd && state == ST_SLEEP && single_eff
            && !(mode_reg.repeat_single_cycle && seq_mode_i == SEQ_MODE1)
            && !pd_stop;
    endsequence
    property p_single_sleep;
        @(posedge clk_i) disable iff (!rst_n)
        s_single_start |-> ##[1:300] state == ST_SLEEP;
    endproperty
    a_single_sleep: assert property (p_single_sleep)
        else $error("Single conversion never returned to sleep.");

    property p_stop_to_sleep;
        @(posedge clk_i) disable iff (!rst_n)
        stop_now && !pd_stop |=> state == ST_SLEEP;
    endproperty
    a_stop_to_sleep: assert property (p_stop_to_sleep)
        else $error("Single conversion did not end in sleep.");

    property p_single_no_latency;
        @(posedge clk_i) disable iff (!rst_n)
        conv_end && cfg_single |-> result_now;
    endproperty
    a_single_no_latency: assert property (p_single_no_latency)
        else $error("Single-cycle result delayed.");

    property p_cont_latency;
        @(posedge clk_i) disable iff (!rst_n)
        conv_end && !cfg_single && settle < SETTLE_CYCLES - 3'h1
            && !settled |-> !result_now;
    endproperty
    a_cont_latency: assert property (p_cont_latency)
        else $error("Continuous result before filter latency.");

    property p_repeat;
        @(posedge clk_i) disable iff (!rst_n)
        conv_end && repeat_eff && cfg_single && !pd_stop |=>
            state == ST_CONV;
    endproperty
    a_repeat: assert property (p_repeat)
        else $error("Repeated single-cycle conversion stopped.");

    property p_low_power_gated;
        @(posedge clk_i) disable iff (!rst_n)
        amp_low_power_o |-> amp_enable_o && $past(opt_reg.amp_enable);
    endproperty
    a_low_power_gated: assert property (p_low_power_gated)
        else $error("Low power active with amplifier off.");

    property p_gain_double;
        @(posedge clk_i) disable iff (!rst_n)
        amp_gain_o == 8'h01 << $past(opt_reg.amp_gain_code);
    endproperty
    a_gain_double: assert property (p_gain_double)
        else $error("Gain does not match gain code.");

    property p_pd_standby;
        @(posedge clk_i) disable iff (!rst_n)
        pd_cmd && mode_reg.power_down_select == PD_STANDBY
            |-> ##2 standby_o;
    endproperty
    a_pd_standby: assert property (p_pd_standby)
        else $error("Standby not entered.");

    property p_offset_binary;
        @(posedge clk_i) disable iff (!rst_n)
        result_now && !cfg_l.unipolar && cfg_l.offset_binary |=>
            data_reg == ($past(sample_i) ^ OFFSET_FLIP);
    endproperty
    a_offset_binary: assert property (p_offset_binary)
        else $error("Offset binary coding wrong.");

endmodule : acm_top

`default_nettype wire

// File: dv/acm_host.sv
// Host controller model that drives the serial register interface.
// Assumes the core clock is given to it; the link clock is made from it.
`default_nettype none

module acm_host (
    input wire logic clk_i,
    input wire logic sdo_i,
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Twenty core cycles per half period give the 160 ns link clock.
    localparam int HALF_CLKS = 20;

    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic half_period();
        repeat (HALF_CLKS) @(negedge clk_i);
    endtask : half_period

    // Link clock stands low outside frames; data in is inverted on release
    // so a design that samples it late cannot see the last bit by luck.
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd,
                        input int nbits, output logic [23:0] rd);
        logic [31:0] sh;
        sh = {cmd, wd};
        rd = '0;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi_o = sh[31 - i];
            half_period();
            sclk_o = 1'b1;
            if (i >= 8) begin
                rd = {rd[22:0], sdo_i};
            end
            half_period();
            sclk_o = 1'b0;
        end
        half_period();
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        half_period();
    endtask : xfer
endmodule : acm_host

`default_nettype wire

// File: dv/acm_top_tb.sv
// Self-checking bench of the converter mode and option control.
// Assumes the host model on the serial pins and a fixed modulator sample.
`default_nettype none

module acm_top_tb;
    import acm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int TIMEOUT_CLKS = 90000;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cs_n, sclk, sdi, sdo, ready_n, converting, standby;
    logic ext_clk, pin0_oe, fault_cur, reg_en, amp_en, amp_lp;
    logic [7:0] amp_gain;
    logic [1:0] seq_mode = SEQ_MODE1;
    logic [23:0] sample = 24'h123456;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    always #2 clk = ~clk;

    acm_top u_dut (.clk_i(clk), .rst_b_i(rst_b), .cs_n_i(cs_n),
        .sclk_i(sclk), .sdi_i(sdi), .sdo_o(sdo), .seq_mode_i(seq_mode),
        .sample_i(sample), .result_ready_n_o(ready_n),
        .converting_o(converting), .standby_o(standby),
        .ext_clock_select_o(ext_clk), .shared_pin0_oe_o(pin0_oe),
        .fault_current_enable_o(fault_cur), .regulator_enable_o(reg_en),
        .amp_enable_o(amp_en), .amp_low_power_o(amp_lp),
        .amp_gain_o(amp_gain));

    acm_host u_host (.clk_i(clk), .sdo_i(sdo), .cs_n_o(cs_n),
        .sclk_o(sclk), .sdi_o(sdi));

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [23:0] seen,
                         input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [23:0] r;
        u_host.xfer({CMD_MODE_REG, a, 1'b0}, {d, 16'h0000}, 16, r);
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [23:0] d);
        u_host.xfer({CMD_MODE_REG, a, 1'b1}, 24'h000000, 32, d);
    endtask : rd

    task automatic cmd(input logic [1:0] mode);
        logic [23:0] r;
        u_host.xfer({mode, 6'h00}, 24'h000000, 8, r);
    endtask : cmd

    // Counts core cycles until a result is reported, with a bound.
    task automatic wait_rdy(output int n);
        n = 0;
        while (ready_n !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check("ready wait", 24'(n < 2000), 24'h000001);
    endtask : wait_rdy

    task automatic check_opt(input logic [7:0] v);
        logic [23:0] r;
        wr(ADDR_OPT, v);
        check("ext clock", 24'(ext_clk), 24'(v[7]));
        check("pin0 oe", 24'(pin0_oe), 24'h000000);
        check("fault current", 24'(fault_cur), 24'(v[6]));
        check("regulator", 24'(reg_en), 24'(v[5]));
        check("low power", 24'(amp_lp), 24'(v[4] & v[3]));
        check("amp enable", 24'(amp_en), 24'(v[3]));
        check("gain", 24'(amp_gain), 24'(8'h01 << v[2:0]));
        rd(ADDR_OPT, r);
        check("option readback", 24'(r[23:16]), 24'(v));
    endtask : check_opt

    task automatic single(input logic [7:0] mode, output logic [23:0] d);
        int n;
        wr(ADDR_MODE, mode);
        cmd(CMD_MODE_CONV);
        wait_rdy(n);
        check("no latency", 24'(n <= CONV_CLKS), 24'h000001);
        repeat (5) @(negedge clk);
        check("sleep after one", 24'(converting), 24'h000000);
        rd(ADDR_DATA, d);
        check("ready cleared", 24'(ready_n), 24'h000001);
    endtask : single

    ////////////////////////////////////////////////////////////////////////
    // A hung handshake would otherwise stall the run forever.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT_CLKS) begin
            mismatches++;
            finish_test();
        end
    end

    initial begin
        logic [23:0] r, d1, d2, d3;
        int n;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("reset regulator", 24'(reg_en), 24'h000001);
        check("reset gain", 24'(amp_gain), 24'h000001);
        check("reset amp", 24'({ext_clk, fault_cur, amp_en}), 24'h0);
        check("reset ready", 24'(ready_n), 24'h000001);
        rst_b = 1'b1;
        repeat (8) @(negedge clk);
        rd(ADDR_OPT, r);
        check("option reset", 24'(r[23:16]), 24'(OPT_RST));
        rd(ADDR_MODE, r);
        check("mode reset", 24'(r[23:16]), 24'(MODE_RST));
        $display("test reset done");

        check_opt(8'h80);
        check_opt(8'h40);
        check_opt(8'h00);
        check_opt(8'h10);
        check_opt(8'h18);
        for (int c = 0; c < 8; c++) begin
            check_opt(8'h28 | 8'(c));
        end
        rd(5'h1F, r);
        check("unmapped read", r, 24'h000000);
        $display("test options done");

        single(8'h0A, d1);
        check("unipolar data", d1, sample);
        single(8'h02, d2);
        single(8'h06, d3);
        check("format flip", d2 ^ d3, OFFSET_FLIP);
        $display("test single done");

        wr(ADDR_MODE, 8'h0B);
        cmd(CMD_MODE_CONV);
        wait_rdy(n);
        repeat (5) @(negedge clk);
        check("repeat mode 1", 24'(converting), 24'h000001);
        wr(ADDR_MODE, 8'h4B);
        cmd(CMD_MODE_PD);
        check("sleep stops", 24'(converting), 24'h000000);
        seq_mode = 2'h2;
        wr(ADDR_MODE, 8'h0B);
        cmd(CMD_MODE_CONV);
        wait_rdy(n);
        repeat (5) @(negedge clk);
        check("no repeat mode 2", 24'(converting), 24'h000000);
        seq_mode = SEQ_MODE1;
        $display("test repeat done");

        wr(ADDR_MODE, 8'h08);
        cmd(CMD_MODE_CONV);
        wait_rdy(n);
        check("latency low", 24'(n > 4 * CONV_CLKS), 24'h000001);
        check("latency high", 24'(n <= 5 * CONV_CLKS), 24'h000001);
        check("continuous", 24'(converting), 24'h000001);
        wr(ADDR_MODE, 8'h40);
        cmd(CMD_MODE_PD);
        check("sleep", 24'({converting, standby}), 24'h000000);
        wr(ADDR_MODE, 8'h80);
        cmd(CMD_MODE_PD);
        check("standby", 24'({converting, standby}), 24'h000001);
        wr(ADDR_OPT, 8'h1F);
        wr(ADDR_MODE, 8'hC0);
        cmd(CMD_MODE_PD);
        rd(ADDR_OPT, r);
        check("pd reset option", 24'(r[23:16]), 24'(OPT_RST));
        check("pd reset gain", 24'(amp_gain), 24'h000001);
        $display("test continuous done");
        finish_test();
    end
endmodule : acm_top_tb

`default_nettype wire
